// *** verilog/psbc_sram_ctrl.sv ***
// control, burst counter and array of the flow-through burst sram
//
// Contract
// [R1] Interleaved order: low address bits are start XOR beat count.
// [R2] Linear order: low address bits advance by one modulo four.
// [R3] Burst counter is two bits and wraps to the start every fourth beat.
// [R4] Every continue cycle advances the counter, also dummy and aborted.
// [R5] Continue cycles keep the read or write type of the loading cycle.
// [R6] Advance after deselect stays deselected with data bus released.
// [R7] Write stores only lanes whose active-low enable is low.
// [R8] All lane enables high: aborted write, nothing stored, bus released.
// [R9] Read with output enable high is a dummy read, bus released.
// [R10] Write cycles release the data drivers whatever output enable says.
// [R11] Clock enable high: edge ignored, all state and counters held.
// [R12] Ignored edge keeps read drive or write release, performs no write.
// [R13] Host raises clock enable for every cycle it wants to stall.
// [R14] All state changes happen on rising clock edges only; the code also clears state asynchronously when i_rst_n falls.
// [R15] Data outputs released from power-up until a read drives them.
// [R16] Host may tie output enable low permanently.
// [R17] Continue cycles ignore selects and read/write for both types.
// [R18] Selects sampled only on load; any inactive select deselects.
// [R19] Snooze: standby, contents kept, other inputs ignored, bus released.
// [R20] Address load sets burst start from the two low address bits.
// [R21] Read/write input is used only when a new address loads.
// [R22] Lane enables sampled with each beat pair with that beat's data.
// [R23] Host keeps burst order static while the device operates.
`timescale 1ns/1ps
`include "psbc_defs.svh"

module psbc_sram_ctrl
    import psbc_pkg::*;
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // synchronous control from the host
    input wire logic i_cke_n,
    input wire logic i_advance_not_load,
    input wire logic i_chip_select_first_n,
    input wire logic i_chip_select_second_n,
    input wire logic i_chip_select_third_hi,
    input wire logic i_read_write_n,
    input wire logic [`PSBC_LANES-1:0] i_lane_write_en_n,
    input wire logic [`PSBC_ADDR_W-1:0] i_addr,
    // asynchronous pins
    input wire logic i_out_enable_n,
    input wire logic i_snooze_request,
    input wire logic i_burst_interleave,
    // data bus, split into in, out and enable
    input wire logic [`PSBC_DATA_W-1:0] i_dq_in,
    output logic [`PSBC_DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    // status
    output logic [4:0] o_state,
    output logic [`PSBC_ADDR_W-1:0] o_addr,
    output logic o_snoozing
);

    // pin synchronisers: output enable, snooze, burst order
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    logic oe_n_sync;
    logic snooze;
    logic interleave;

    // operation state
    psbc_state_t state_ff;
    psbc_state_t nxt_state;
    logic [`PSBC_BEAT_W-1:0] beat_ff;
    logic [`PSBC_BEAT_W-1:0] nxt_beat;
    logic [`PSBC_BEAT_W-1:0] start_ff;
    logic [`PSBC_BEAT_W-1:0] nxt_start;
    logic [`PSBC_ADDR_W-1:0] addr_ff;
    logic [`PSBC_ADDR_W-1:0] nxt_addr;
    // write posted for the data of the next active edge
    logic wr_pend_ff;
    logic nxt_wr_pend;
    logic [`PSBC_ADDR_W-1:0] wr_addr_ff;
    logic [`PSBC_ADDR_W-1:0] nxt_wr_addr;
    logic [`PSBC_LANES-1:0] wr_mask_ff;
    logic [`PSBC_LANES-1:0] nxt_wr_mask;
    // output registers
    logic [`PSBC_DATA_W-1:0] dq_out_ff;
    logic [`PSBC_DATA_W-1:0] nxt_dq_out;
    logic dq_oe_ff;
    logic nxt_dq_oe;
    logic snoozing_ff;

    // decoded controls
    logic active;
    logic selected;
    logic cur_is_wr;
    logic nxt_is_rd;
    logic [`PSBC_BEAT_W-1:0] beat_next;
    logic [`PSBC_BEAT_W-1:0] step_lsb;
    logic [`PSBC_ADDR_W-1:0] rd_addr;
    logic [`PSBC_DATA_W-1:0] rd_word;
    logic [`PSBC_LANES-1:0] lane_we;

    // two flops per pin; only the second stage is read below
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_meta_ff <= 3'h1;
            pin_sync_ff <= 3'h1;
        end
        else
        begin
            pin_meta_ff <= {i_burst_interleave, i_snooze_request,
                            i_out_enable_n};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    assign oe_n_sync = pin_sync_ff[0];
    assign snooze = pin_sync_ff[1];
    assign interleave = pin_sync_ff[2]; // [R23]

    // an edge counts only with clock enable low and no snooze
    assign active = !i_cke_n && !snooze; // [R11] [R19]
    assign selected = !i_chip_select_first_n && !i_chip_select_second_n &&
                      i_chip_select_third_hi; // [R18]
    assign cur_is_wr = (state_ff == PSBC_ST_NEW_WR) ||
                       (state_ff == PSBC_ST_BUR_WR);
    assign beat_next = beat_ff + `PSBC_BEAT_STEP; // [R3]

    psbc_burst_step u_step (
        .i_start(start_ff),
        .i_beat(beat_next),
        .i_interleave(interleave),
        .o_lsb(step_lsb)
    );

    // flow-through read address: loaded address or next burst address
    assign rd_addr = i_advance_not_load ?
                     {addr_ff[`PSBC_ADDR_W-1:`PSBC_BEAT_W], step_lsb} :
                     i_addr;

    // posted write lands on the next active edge with that edge's data
    genvar gl;
    generate
        for (gl = 0; gl < `PSBC_LANES; gl = gl + 1)
        begin : g_lane
            logic [`PSBC_LANE_W-1:0] mem [0:`PSBC_DEPTH-1];
            assign lane_we[gl] = active && wr_pend_ff &&
                                 wr_mask_ff[gl]; // [R7] [R12] [R22]
            always_ff @(posedge i_mclk)
            begin
                if (lane_we[gl])
                    mem[wr_addr_ff] <=
                        i_dq_in[gl*`PSBC_LANE_W +: `PSBC_LANE_W];
            end
            assign rd_word[gl*`PSBC_LANE_W +: `PSBC_LANE_W] = mem[rd_addr];
        end
    endgenerate

    // next-state decode; a stalled edge leaves every value as it was
    always_comb
    begin
        nxt_state = state_ff;
        nxt_beat = beat_ff;
        nxt_start = start_ff;
        nxt_addr = addr_ff;
        nxt_wr_pend = wr_pend_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_mask = wr_mask_ff;
        nxt_dq_out = dq_out_ff;
        if (snooze)
        begin
            // standby drops a posted write; the array is untouched
            nxt_state = PSBC_ST_DESEL; // [R19]
            nxt_wr_pend = 1'b0;
        end
        else if (active)
        begin
            nxt_wr_pend = 1'b0;
            if (!i_advance_not_load)
            begin
                if (!selected)
                    nxt_state = PSBC_ST_DESEL; // [R18]
                else
                begin
                    nxt_addr = i_addr;
                    nxt_start = i_addr[`PSBC_BEAT_W-1:0]; // [R20]
                    nxt_beat = `PSBC_BEAT_FIRST; // [R20]
                    if (i_read_write_n) // [R21]
                    begin
                        nxt_state = PSBC_ST_NEW_RD;
                        nxt_dq_out = rd_word;
                    end
                    else
                    begin
                        nxt_state = PSBC_ST_NEW_WR;
                        nxt_wr_pend = 1'b1;
                        nxt_wr_addr = i_addr;
                        nxt_wr_mask = ~i_lane_write_en_n; // [R7] [R22]
                    end
                end
            end
            else if (state_ff != PSBC_ST_DESEL) // [R6] [R17]
            begin
                nxt_beat = beat_next; // [R4]
                nxt_addr = rd_addr; // [R1] [R2]
                if (cur_is_wr) // [R5]
                begin
                    nxt_state = PSBC_ST_BUR_WR;
                    nxt_wr_pend = 1'b1;
                    nxt_wr_addr = rd_addr;
                    nxt_wr_mask = ~i_lane_write_en_n; // [R8] [R22]
                end
                else
                begin
                    nxt_state = PSBC_ST_BUR_RD;
                    nxt_dq_out = rd_word;
                end
            end
        end
    end

    // drive only for reads with output enable low; writes never drive
    assign nxt_is_rd = (nxt_state == PSBC_ST_NEW_RD) ||
                       (nxt_state == PSBC_ST_BUR_RD);
    assign nxt_dq_oe = nxt_is_rd && !oe_n_sync; // [R9] [R10] [R12]

    // all state registers change on the rising edge, or at once when reset goes low
    always_ff @(posedge i_mclk or negedge i_rst_n) // [R14]
    begin
        if (!i_rst_n)
        begin
            state_ff <= PSBC_ST_DESEL;
            beat_ff <= `PSBC_BEAT_FIRST;
            start_ff <= `PSBC_BEAT_FIRST;
            addr_ff <= '0;
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            wr_mask_ff <= `PSBC_MASK_NONE;
            dq_out_ff <= '0;
            dq_oe_ff <= 1'b0; // [R15]
            snoozing_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            beat_ff <= nxt_beat;
            start_ff <= nxt_start;
            addr_ff <= nxt_addr;
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            wr_mask_ff <= nxt_wr_mask;
            dq_out_ff <= nxt_dq_out;
            dq_oe_ff <= nxt_dq_oe;
            snoozing_ff <= snooze;
        end
    end

    assign o_dq_out = dq_out_ff;
    assign o_dq_oe = dq_oe_ff;
    assign o_state = state_ff;
    assign o_addr = addr_ff;
    assign o_snoozing = snoozing_ff;

    // checks on the control behaviour
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_continue;
        active && i_advance_not_load && (state_ff != PSBC_ST_DESEL);
    endsequence

    sequence s_load_access;
        active && !i_advance_not_load && selected;
    endsequence

    a_interleave_order: assert property ( // [R1]
        ((state_ff == PSBC_ST_BUR_RD) || (state_ff == PSBC_ST_BUR_WR)) &&
        interleave && $stable(interleave)
        |-> addr_ff[1:0] == (start_ff ^ beat_ff))
        else $error("interleaved burst address wrong");

    a_linear_order: assert property ( // [R2]
        ((state_ff == PSBC_ST_BUR_RD) || (state_ff == PSBC_ST_BUR_WR)) &&
        !interleave && $stable(interleave)
        |-> addr_ff[1:0] == 2'(start_ff + beat_ff))
        else $error("linear burst address wrong");

    a_burst_wraps: assert property ( // [R3]
        s_continue ##1 s_continue ##1 s_continue ##1 s_continue
        |=> addr_ff == $past(addr_ff, 4))
        else $error("burst did not wrap after four beats");

    a_counter_advance: assert property ( // [R4]
        s_continue |=> beat_ff == 2'($past(beat_ff) + 2'h1))
        else $error("burst counter did not advance");

    a_type_kept: assert property ( // [R5]
        s_continue |=> (cur_is_wr == $past(cur_is_wr)))
        else $error("continue cycle changed read or write type");

    a_desel_stays: assert property ( // [R6]
        active && i_advance_not_load && (state_ff == PSBC_ST_DESEL)
        |=> (state_ff == PSBC_ST_DESEL) && !o_dq_oe)
        else $error("continue deselect left deselect");

    a_abort_no_store: assert property ( // [R8]
        s_load_access ##0 (!i_read_write_n && (&i_lane_write_en_n))
        |=> !o_dq_oe && (lane_we == `PSBC_MASK_NONE))
        else $error("aborted write changed the array");

    a_write_no_drive: assert property ( // [R10]
        cur_is_wr |-> !o_dq_oe)
        else $error("data driven during a write");

    a_stall_holds: assert property ( // [R11]
        i_cke_n && !snooze
        |=> $stable(state_ff) && $stable(beat_ff) && $stable(addr_ff))
        else $error("state changed on an ignored edge");

    a_stall_no_write: assert property ( // [R12]
        i_cke_n |-> lane_we == `PSBC_MASK_NONE)
        else $error("write performed on an ignored edge");

    a_load_start: assert property ( // [R20]
        s_load_access |=> (beat_ff == 2'h0) &&
                          (start_ff == $past(i_addr[1:0])))
        else $error("burst start not loaded from address");

    a_snooze_release: assert property ( // [R19]
        snooze |=> !o_dq_oe && (state_ff == PSBC_ST_DESEL))
        else $error("bus driven in snooze");

endmodule : psbc_sram_ctrl

// *** verilog/psbc_defs.svh ***
// constants for the pipelineless sram burst control block
`ifndef PSBC_DEFS_SVH
`define PSBC_DEFS_SVH

// array geometry: 512k words of four byte lanes
`define PSBC_ADDR_W 19
`define PSBC_DEPTH 524288
`define PSBC_LANES 4
`define PSBC_LANE_W 8
`define PSBC_DATA_W 32

// burst counter width and beat index at address load
`define PSBC_BEAT_W 2
`define PSBC_BEAT_FIRST 2'h0
`define PSBC_BEAT_STEP 2'h1

// lane mask meaning no lane written (aborted write)
`define PSBC_MASK_NONE 4'h0

// one-hot state codes
`define PSBC_ST_DESEL 5'h01
`define PSBC_ST_NEW_RD 5'h02
`define PSBC_ST_NEW_WR 5'h04
`define PSBC_ST_BUR_RD 5'h08
`define PSBC_ST_BUR_WR 5'h10

`endif

// *** verilog/psbc_pkg.sv ***
// types for the pipelineless sram burst control block
`include "psbc_defs.svh"

package psbc_pkg;

    // operation state: deselect, new read, new write, burst read/write
    typedef enum logic [4:0] {
        PSBC_ST_DESEL = `PSBC_ST_DESEL,
        PSBC_ST_NEW_RD = `PSBC_ST_NEW_RD,
        PSBC_ST_NEW_WR = `PSBC_ST_NEW_WR,
        PSBC_ST_BUR_RD = `PSBC_ST_BUR_RD,
        PSBC_ST_BUR_WR = `PSBC_ST_BUR_WR
    } psbc_state_t;

endpackage : psbc_pkg

// *** verilog/psbc_burst_step.sv ***
// burst order stepper for the two low address bits
`timescale 1ns/1ps
`include "psbc_defs.svh"

module psbc_burst_step
    import psbc_pkg::*;
(
    // burst start and beat index
    input wire logic [`PSBC_BEAT_W-1:0] i_start,
    input wire logic [`PSBC_BEAT_W-1:0] i_beat,
    // burst order: high is interleaved, low is linear
    input wire logic i_interleave,
    // stepped low address bits
    output logic [`PSBC_BEAT_W-1:0] o_lsb
);

    // a two-bit result wraps to the start every fourth beat
    always_comb
    begin
        if (i_interleave)
            o_lsb = i_start ^ i_beat; // [R1] [R3]
        else
            o_lsb = i_start + i_beat; // [R2] [R3]
    end

endmodule : psbc_burst_step

// *** verif/psbc_host.sv ***
// host memory controller model driving the burst sram control pins
`timescale 1ns/1ps

module psbc_host (
    // clock and bus as driven by the device
    input wire logic i_mclk,
    input wire logic [31:0] i_dq_out,
    input wire logic i_dq_oe,
    // synchronous control
    output logic o_cke_n = 1'b0,
    output logic o_adv = 1'b1,
    output logic o_cs1_n = 1'b0,
    output logic o_cs2_n = 1'b0,
    output logic o_cs3 = 1'b1,
    output logic o_rw_n = 1'b1,
    output logic [3:0] o_lane_n = 4'hf,
    output logic [18:0] o_addr = 19'h0,
    // asynchronous pins and the shared data wire
    output logic o_oe_n = 1'b0,
    output logic o_snz = 1'b0,
    output logic o_il = 1'b0,
    output logic [31:0] o_dq
);
    logic drv = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] last = 32'h0;

    // nobody driving: wire toggles so a stale value never looks valid
    assign o_dq = i_dq_oe ? i_dq_out : (drv ? wd : ~last);

    // remember the wire level of the previous cycle
    always @(posedge i_mclk)
        last <= o_dq;

    // one bus cycle; continue beats use the same controls for both types
    task automatic op(input logic adv, input logic rw_n,
        input logic [3:0] ln, input logic [18:0] a,
        input logic dv, input logic [31:0] d);
        o_adv = adv;
        o_rw_n = rw_n;
        o_lane_n = ln;
        o_addr = a;
        drv = dv;
        wd = d;
        @(posedge i_mclk);
        #1;
    endtask : op
endmodule : psbc_host

// *** verif/psbc_sram_ctrl_bench.sv ***
// self-checking bench for the burst sram control block
`timescale 1ns/1ps

module psbc_sram_ctrl_bench
    import psbc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    wire cke_n, adv, cs1_n, cs2_n, cs3, rw_n, oe_n, snz, il;
    wire [3:0] lane_n;
    wire [18:0] addr_i;
    wire [31:0] dq_in;
    logic [31:0] dq_out;
    logic dq_oe;
    logic [4:0] state;
    logic [18:0] addr_o;
    logic snoozing;
    int err_count = 0;
    int n_tests = 0;
    logic mode = 1'b0;
    logic [31:0] exp_mem [int];

    // clock at 50 MHz
    always #10 mclk = ~mclk;

    psbc_host host (.i_mclk(mclk), .i_dq_out(dq_out), .i_dq_oe(dq_oe),
        .o_cke_n(cke_n), .o_adv(adv), .o_cs1_n(cs1_n), .o_cs2_n(cs2_n),
        .o_cs3(cs3), .o_rw_n(rw_n), .o_lane_n(lane_n), .o_addr(addr_i),
        .o_oe_n(oe_n), .o_snz(snz), .o_il(il), .o_dq(dq_in));

    psbc_sram_ctrl dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_cke_n(cke_n),
        .i_advance_not_load(adv), .i_chip_select_first_n(cs1_n),
        .i_chip_select_second_n(cs2_n), .i_chip_select_third_hi(cs3),
        .i_read_write_n(rw_n), .i_lane_write_en_n(lane_n),
        .i_addr(addr_i), .i_out_enable_n(oe_n), .i_snooze_request(snz),
        .i_burst_interleave(il), .i_dq_in(dq_in), .o_dq_out(dq_out),
        .o_dq_oe(dq_oe), .o_state(state), .o_addr(addr_o),
        .o_snoozing(snoozing));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // address of beat b in the current burst order
    function automatic logic [18:0] ea(input logic [18:0] a, input int b);
        logic [1:0] s;
        s = mode ? a[1:0] ^ b[1:0] : a[1:0] + b[1:0];
        return {a[18:2], s};
    endfunction : ea

    // lanes with a low enable take the new byte
    function automatic logic [31:0] mrg(input logic [31:0] o,
        input logic [31:0] n, input logic [3:0] ln);
        for (int i = 0; i < 4; i++)
            if (!ln[i])
                o[i*8 +: 8] = n[i*8 +: 8];
        return o;
    endfunction : mrg

    // deselect cycles; a deselect edge also lands a posted write
    task automatic idle(input int n);
        host.o_cs1_n = 1'b1;
        repeat (n) host.op(1'b0, 1'b1, 4'hf, 19'h0, 1'b0, 32'h0);
        host.o_cs1_n = 1'b0;
    endtask : idle

    // write burst of n beats, data d0+beat, lanes per beat in ln
    task automatic wr(input logic [18:0] a, input int n,
        input logic [19:0] ln, input logic [31:0] d0);
        int k;
        for (int b = 0; b <= n; b++)
        begin
            host.o_cs1_n = (b == n);
            host.op(b > 0 && b < n, 1'b0, ln[4*(b%5) +: 4], a, b > 0,
                d0 + b - 1);
            if (b > 0)
            begin
                k = ea(a, b - 1);
                exp_mem[k] = mrg(exp_mem.exists(k) ? exp_mem[k] : 32'hx,
                    d0 + b - 1, ln[4*(b-1) +: 4]);
            end
            if (b < n)
            begin
                chk("addr", addr_o, ea(a, b));
                chk("state", state,
                    b == 0 ? PSBC_ST_NEW_WR : PSBC_ST_BUR_WR);
                chk("oe", dq_oe, 1'b0);
            end
        end
        host.o_cs1_n = 1'b0;
    endtask : wr

    // read burst of n beats checked against the expected array
    task automatic rd(input logic [18:0] a, input int n);
        for (int b = 0; b < n; b++)
        begin
            host.op(b > 0, 1'b1, 4'hf, a, 1'b0, 32'h0);
            chk("addr", addr_o, ea(a, b));
            chk("state", state,
                b == 0 ? PSBC_ST_NEW_RD : PSBC_ST_BUR_RD);
            chk("oe", dq_oe, !host.o_oe_n);
            if (!host.o_oe_n)
                chk("data", dq_out, exp_mem[int'(ea(a, b))]);
        end
    endtask : rd

    // verdict
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    // watchdog, far beyond the roughly 70 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk("oe", dq_oe, 1'b0);
        host.op(1'b1, 1'b1, 4'hf, 19'h0, 1'b0, 32'h0);
        chk("state", state, PSBC_ST_DESEL);
        chk("oe", dq_oe, 1'b0);
        idle(2);
        $display("test reset done");
        // linear burst wraps onto its start at the fifth beat
        wr(19'h101, 5, 20'h00000, 32'h11223340);
        // partial lanes, then an aborted continue beat
        wr(19'h102, 2, 20'h000f5, 32'haabbccdd);
        // aborted write on the loading cycle leaves the word alone
        wr(19'h103, 1, 20'h0000f, 32'hdeadbeef);
        // stall inside a write: bus stays released, write waits its edge
        host.op(1'b0, 1'b0, 4'h0, 19'h100, 1'b0, 32'h0);
        host.o_cke_n = 1'b1;
        repeat (2) host.op(1'b1, 1'b1, 4'h0, 19'h0, 1'b1, 32'h0badf00d);
        chk("state", state, PSBC_ST_NEW_WR);
        chk("oe", dq_oe, 1'b0);
        host.o_cke_n = 1'b0;
        host.o_cs1_n = 1'b1;
        host.op(1'b0, 1'b1, 4'hf, 19'h0, 1'b1, 32'h55aa55aa);
        host.o_cs1_n = 1'b0;
        exp_mem[19'h100] = 32'h55aa55aa;
        rd(19'h100, 4);
        $display("test linear done");
        // stall mid read, then a continue with read/write low
        host.op(1'b0, 1'b1, 4'hf, 19'h102, 1'b0, 32'h0);
        host.o_cke_n = 1'b1;
        repeat (2) host.op(1'b1, 1'b0, 4'h0, 19'h0, 1'b1, 32'h0);
        chk("addr", addr_o, 19'h102);
        chk("state", state, PSBC_ST_NEW_RD);
        chk("oe", dq_oe, 1'b1);
        host.o_cke_n = 1'b0;
        host.op(1'b1, 1'b0, 4'h0, 19'h0, 1'b0, 32'h0);
        chk("state", state, PSBC_ST_BUR_RD);
        chk("data", dq_out, exp_mem[32'h103]);
        $display("test stall done");
        // each select on its own deselects
        for (int i = 0; i < 3; i++)
        begin
            {host.o_cs1_n, host.o_cs2_n, host.o_cs3} = 3'b001 ^ (3'b100 >> i);
            host.op(1'b0, 1'b1, 4'hf, 19'h100, 1'b0, 32'h0);
            chk("state", state, PSBC_ST_DESEL);
            chk("oe", dq_oe, 1'b0);
        end
        {host.o_cs1_n, host.o_cs2_n, host.o_cs3} = 3'b001;
        $display("test selects done");
        // dummy read still steps the counter
        host.o_oe_n = 1'b1;
        idle(3);
        rd(19'h100, 2);
        host.o_oe_n = 1'b0;
        // burst order changed only while idle
        host.o_il = 1'b1;
        mode = 1'b1;
        idle(3);
        rd(19'h101, 4);
        $display("test order done");
        // snooze ignores loads, keeps contents
        host.o_snz = 1'b1;
        repeat (4) host.op(1'b0, 1'b1, 4'hf, 19'h100, 1'b0, 32'h0);
        chk("snooze", snoozing, 1'b1);
        chk("state", state, PSBC_ST_DESEL);
        chk("oe", dq_oe, 1'b0);
        host.o_snz = 1'b0;
        idle(4);
        chk("snooze", snoozing, 1'b0);
        rd(19'h102, 1);
        $display("test snooze done");
        report_and_stop();
    end
endmodule : psbc_sram_ctrl_bench
